// ==== logic/audio_serial_map.vh ====
// Register offsets, field positions and reset values of the serial channel control.
// Assumes inclusion by bare name from the design files; holds definitions only.
`ifndef AUDIO_SERIAL_MAP_VH
`define AUDIO_SERIAL_MAP_VH

// Register offsets on the register port
`define CTRL_OFS        6'h20
`define P1_COUNT_OFS    6'h24
`define P2_COUNT_OFS    6'h28
`define REC_COUNT_OFS   6'h2C

// Control register reset value and fixed-ones field
`define CTRL_RESET      32'hFF800000
`define CTRL_Q_RESET    23'h000000
`define CTRL_ONES       32'hFF800000
`define CTRL_WMASK      32'h007FFFFF
`define COUNT_RESET     16'h0000

// Control register field positions
`define REC_LOOP_BIT    15
`define P2_LOOP_BIT     14
`define P1_LOOP_BIT     13
`define P2_PAUSE_BIT    12
`define P1_HOLD_BIT     11
`define REC_IRQ_BIT     10
`define P2_IRQ_BIT      9
`define P1_IRQ_BIT      8
`define P1_RELOAD_BIT   7
`define P2_KEEP_BIT     6
`define REC_WIDE_BIT    5
`define REC_STEREO_BIT  4
`define P2_WIDE_BIT     3
`define P2_STEREO_BIT   2
`define P1_WIDE_BIT     1
`define P1_STEREO_BIT   0

`endif

// ==== logic/sample_counter.v ====
// Per-channel live sample counter with reload, loop and stop behaviour.
// Assumes tick and reload come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module sample_counter #(
   parameter W = 16
) (
   // Clock and reset
   input  wire         clock,
   input  wire         rst,
   // Control
   input  wire         reload,
   input  wire [W-1:0] load_value,
   input  wire         tick,
   input  wire         loop_mode,
   // Status
   output reg  [W-1:0] live_q,
   output reg          stopped_q,
   output wire         done
);

   // Last frame of the buffer is the one taken while the counter shows zero
   assign done = tick & ~stopped_q & (live_q == {W{1'b0}});

   // Reload wins over a tick in the same cycle so a restart is never skipped
   always @(posedge clock)
   begin
      if (rst)
      begin
         live_q    <= {W{1'b0}};
         stopped_q <= 1'b0;
      end
      else if (reload)
      begin
         live_q    <= load_value;
         stopped_q <= 1'b0;
      end
      else if (done)
      begin
         if (loop_mode)
            live_q <= load_value;
         else
            stopped_q <= 1'b1;
      end
      else if (tick & ~stopped_q)
         live_q <= live_q - {{(W-1){1'b0}}, 1'b1};
   end

endmodule

`default_nettype wire

// ==== logic/two_entry_buffer.v ====
// Small valid/ready buffer for record words on their way to memory.
// Assumes both sides run on the same clock; DEPTH must be 2**AW.
`timescale 1ns/1ps
`default_nettype none

module two_entry_buffer #(
   parameter WIDTH = 32,
   parameter DEPTH = 2,
   parameter AW    = 1
) (
   // Clock and reset
   input  wire             clock,
   input  wire             rst,
   // Filling side
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   // Draining side
   output wire [WIDTH-1:0] out_data,
   output wire             out_valid,
   input  wire             out_ready
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wp_q;
   reg [AW-1:0]    rp_q;
   reg [AW:0]      cnt_q;
   wire            push;
   wire            pop;
   localparam [AW-1:0] PTR_ONE  = 1;
   localparam [AW:0]   CNT_ONE  = 1;
   localparam [AW:0]   CNT_FULL = DEPTH;

   // Honest full and empty straight from the occupancy count
   assign in_ready  = (cnt_q != CNT_FULL);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data  = mem[rp_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Storage write, no reset needed for the data words
   always @(posedge clock)
   begin
      if (push)
         mem[wp_q] <= in_data;
   end

   // Pointers and count
   always @(posedge clock)
   begin
      if (rst)
      begin
         wp_q  <= {AW{1'b0}};
         rp_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wp_q <= wp_q + PTR_ONE;
         if (pop)
            rp_q <= rp_q + PTR_ONE;
         if (push & ~pop)
            cnt_q <= cnt_q + CNT_ONE;
         else if (pop & ~push)
            cnt_q <= cnt_q - CNT_ONE;
      end
   end

endmodule

`default_nettype wire

// ==== logic/audio_channel_serial_control.v ====
// Serial channel control: two playback channels and one record channel.
// Assumes the register port and DMA side share clock; lrclk and record
// samples come from the codec and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "audio_serial_map.vh"

module audio_channel_serial_control #(
   parameter CW = 16
) (
   // Clock and reset
   input  wire          clock,
   input  wire          rst,
   // Register port
   input  wire [5:0]    reg_addr,
   input  wire          reg_wr,
   input  wire          reg_rd,
   input  wire [3:0]    reg_be,
   input  wire [31:0]   reg_wdata,
   output reg  [31:0]   reg_rdata_q,
   // Codec link
   input  wire          lrclk,
   input  wire [15:0]   rec_left_in,
   input  wire [15:0]   rec_right_in,
   output reg  [15:0]   p1_left_q,
   output reg  [15:0]   p1_right_q,
   output reg  [15:0]   p2_left_q,
   output reg  [15:0]   p2_right_q,
   // Channel enables from the DMA side
   input  wire          p1_enable,
   input  wire          p2_enable,
   input  wire          rec_enable,
   // Playback fetch from the sample cache
   input  wire [31:0]   p1_fetch_data,
   input  wire          p1_fetch_valid,
   output wire          p1_fetch_ready,
   input  wire [31:0]   p2_fetch_data,
   input  wire          p2_fetch_valid,
   output wire          p2_fetch_ready,
   // Record store toward memory
   output wire [31:0]   rec_store_data,
   output wire          rec_store_valid,
   input  wire          rec_store_ready,
   // Channel interrupt levels
   output reg           p1_irq_q,
   output reg           p2_irq_q,
   output reg           rec_irq_q
);

   // Byte-lane merge of a write into an old register value
   function [31:0] merge;
      input [31:0] old;
      input [31:0] wd;
      input [3:0]  be;
      integer      i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1)
            if (be[i])
               merge[i*8 +: 8] = wd[i*8 +: 8];
      end
   endfunction

   // Playback slot: eight-bit byte goes to the top with msb flipped
   function [15:0] play_conv;
      input [15:0] s;
      input        wide;
      begin
         play_conv = wide ? s : {~s[7], s[6:0], 8'h00};
      end
   endfunction

   // Record slot: top byte kept with msb flipped for eight-bit formats
   function [15:0] rec_conv;
      input [15:0] s;
      input        wide;
      begin
         rec_conv = wide ? s : {8'h00, ~s[15], s[14:8]};
      end
   endfunction

   // Register state
   reg  [22:0]   ctrl_q;
   reg  [15:0]   p1_cnt_q;
   reg  [15:0]   p2_cnt_q;
   reg  [15:0]   rec_cnt_q;
   reg           reload_pend_q;
   wire [31:0]   ctrl_full;
   wire [31:0]   ctrl_d;
   wire          ctrl_wr;
   wire          reload_rise;

   // Link synchronisers and edge detect
   reg  [2:0]    lr_sync_q;
   reg  [15:0]   recl_m_q;
   reg  [15:0]   recl_s_q;
   reg  [15:0]   recr_m_q;
   reg  [15:0]   recr_s_q;
   wire          frame;

   // Channel state
   reg           p1_en_q;
   reg           p2_en_q;
   reg           rec_en_q;
   wire [15:0]   p1_live;
   wire [15:0]   p2_live;
   wire [15:0]   rec_live;
   wire          p1_stop;
   wire          p2_stop;
   wire          rec_stop;
   wire          p1_done;
   wire          p2_done;
   wire          rec_done;
   wire          p1_take;
   wire          p2_take;
   wire          rec_push;
   wire          rec_accept;
   wire          rec_in_ready;
   wire [31:0]   rec_word;
   wire [15:0]   p1_l;
   wire [15:0]   p1_r;
   wire [15:0]   p2_l;
   wire [15:0]   p2_r;
   wire [15:0]   rec_l;
   wire [15:0]   rec_r;

   // Control write: upper nine bits are fixed ones and never stored
   assign ctrl_full = `CTRL_ONES | {9'h000, ctrl_q};
   assign ctrl_wr   = reg_wr & (reg_addr == `CTRL_OFS);
   assign ctrl_d    = (merge(ctrl_full, reg_wdata, reg_be) & `CTRL_WMASK) | `CTRL_ONES;

   // Only a 0-to-1 write of the reload bit counts; level is ignored
   assign reload_rise = ctrl_wr & ~ctrl_q[`P1_RELOAD_BIT]
                        & ctrl_d[`P1_RELOAD_BIT];

   // Register writes
   always @(posedge clock)
   begin
      if (rst)
      begin
         ctrl_q    <= `CTRL_Q_RESET;
         p1_cnt_q  <= `COUNT_RESET;
         p2_cnt_q  <= `COUNT_RESET;
         rec_cnt_q <= `COUNT_RESET;
      end
      else if (reg_wr)
      begin
         if (reg_addr == `CTRL_OFS)
            ctrl_q <= ctrl_d[22:0];
         if (reg_addr == `P1_COUNT_OFS)
            p1_cnt_q <= {reg_be[1] ? reg_wdata[15:8] : p1_cnt_q[15:8],
                         reg_be[0] ? reg_wdata[7:0] : p1_cnt_q[7:0]};
         if (reg_addr == `P2_COUNT_OFS)
            p2_cnt_q <= {reg_be[1] ? reg_wdata[15:8] : p2_cnt_q[15:8],
                         reg_be[0] ? reg_wdata[7:0] : p2_cnt_q[7:0]};
         if (reg_addr == `REC_COUNT_OFS)
            rec_cnt_q <= {reg_be[1] ? reg_wdata[15:8] : rec_cnt_q[15:8],
                          reg_be[0] ? reg_wdata[7:0] : rec_cnt_q[7:0]};
      end
   end

   // Registered read data; unmapped offsets read as zero
   always @(posedge clock)
   begin
      if (rst)
         reg_rdata_q <= 32'h00000000;
      else if (reg_rd)
      begin
         case (reg_addr)
            `CTRL_OFS:      reg_rdata_q <= ctrl_full;
            `P1_COUNT_OFS:  reg_rdata_q <= {p1_live, p1_cnt_q};
            `P2_COUNT_OFS:  reg_rdata_q <= {p2_live, p2_cnt_q};
            `REC_COUNT_OFS: reg_rdata_q <= {rec_live, rec_cnt_q};
            default:        reg_rdata_q <= 32'h00000000;
         endcase
      end
   end

   // Pending reload waits for the next lrclk rise; a new rise wins over the clear
   always @(posedge clock)
   begin
      if (rst)
         reload_pend_q <= 1'b0;
      else if (reload_rise)
         reload_pend_q <= 1'b1;
      else if (frame)
         reload_pend_q <= 1'b0;
   end

   // Two flops before use; the third stage only feeds the edge detector
   always @(posedge clock)
   begin
      if (rst)
      begin
         lr_sync_q <= 3'h0;
         recl_m_q  <= 16'h0000;
         recl_s_q  <= 16'h0000;
         recr_m_q  <= 16'h0000;
         recr_s_q  <= 16'h0000;
      end
      else
      begin
         lr_sync_q <= {lr_sync_q[1:0], lrclk};
         recl_m_q  <= rec_left_in;
         recl_s_q  <= recl_m_q;
         recr_m_q  <= rec_right_in;
         recr_s_q  <= recr_m_q;
      end
   end

   // One frame per lrclk rising edge
   assign frame = lr_sync_q[1] & ~lr_sync_q[2];

   // Enable history for start detection
   always @(posedge clock)
   begin
      if (rst)
      begin
         p1_en_q  <= 1'b0;
         p2_en_q  <= 1'b0;
         rec_en_q <= 1'b0;
      end
      else
      begin
         p1_en_q  <= p1_enable;
         p2_en_q  <= p2_enable;
         rec_en_q <= rec_enable;
      end
   end

   // Playback one fetches only on a frame while running and not paused
   assign p1_fetch_ready = frame & p1_enable & ~p1_stop
                           & ~ctrl_q[`P1_HOLD_BIT];
   assign p1_take = p1_fetch_ready & p1_fetch_valid;
   assign p1_l    = play_conv(p1_fetch_data[15:0], ctrl_q[`P1_WIDE_BIT]);
   assign p1_r    = ctrl_q[`P1_STEREO_BIT] ?
                    play_conv(p1_fetch_data[31:16], ctrl_q[`P1_WIDE_BIT]) : p1_l;

   // Playback two has no pause here; the pause bit is stored only
   assign p2_fetch_ready = frame & p2_enable & ~p2_stop;
   assign p2_take = p2_fetch_ready & p2_fetch_valid;
   assign p2_l    = play_conv(p2_fetch_data[15:0], ctrl_q[`P2_WIDE_BIT]);
   assign p2_r    = ctrl_q[`P2_STEREO_BIT] ?
                    play_conv(p2_fetch_data[31:16], ctrl_q[`P2_WIDE_BIT]) : p2_l;

   // Playback one outputs; an underrun or pause simply repeats the last sample
   always @(posedge clock)
   begin
      if (rst)
      begin
         p1_left_q  <= 16'h0000;
         p1_right_q <= 16'h0000;
      end
      else if (p1_take)
      begin
         p1_left_q  <= p1_l;
         p1_right_q <= p1_r;
      end
   end

   // Disabled playback two goes silent unless told to keep its stopped sample
   always @(posedge clock)
   begin
      if (rst)
      begin
         p2_left_q  <= 16'h0000;
         p2_right_q <= 16'h0000;
      end
      else if (~p2_enable)
      begin
         if (~(ctrl_q[`P2_KEEP_BIT] & p2_stop))
         begin
            p2_left_q  <= 16'h0000;
            p2_right_q <= 16'h0000;
         end
      end
      else if (p2_take)
      begin
         p2_left_q  <= p2_l;
         p2_right_q <= p2_r;
      end
   end

   // Record word: mono leaves the right slot empty and ignores right data
   assign rec_l    = rec_conv(recl_s_q, ctrl_q[`REC_WIDE_BIT]);
   assign rec_r    = ctrl_q[`REC_STEREO_BIT] ?
                     rec_conv(recr_s_q, ctrl_q[`REC_WIDE_BIT]) : 16'h0000;
   assign rec_word = {rec_r, rec_l};
   assign rec_push = frame & rec_enable & ~rec_stop;
   // A full buffer stalls the counter so the count matches stored frames
   assign rec_accept = rec_push & rec_in_ready;

   two_entry_buffer #(
      .WIDTH (32),
      .DEPTH (2),
      .AW    (1)
   ) rec_buffer (
      .clock     (clock),
      .rst       (rst),
      .in_data   (rec_word),
      .in_valid  (rec_push),
      .in_ready  (rec_in_ready),
      .out_data  (rec_store_data),
      .out_valid (rec_store_valid),
      .out_ready (rec_store_ready)
   );

   // Counters: start on enable rise; playback one also on pending reload
   sample_counter #(.W(CW)) p1_counter (
      .clock      (clock),
      .rst        (rst),
      .reload     ((frame & reload_pend_q) | (p1_enable & ~p1_en_q)),
      .load_value (p1_cnt_q),
      .tick       (p1_take),
      .loop_mode  (~ctrl_q[`P1_LOOP_BIT]),
      .live_q     (p1_live),
      .stopped_q  (p1_stop),
      .done       (p1_done)
   );

   sample_counter #(.W(CW)) p2_counter (
      .clock      (clock),
      .rst        (rst),
      .reload     (p2_enable & ~p2_en_q),
      .load_value (p2_cnt_q),
      .tick       (p2_take),
      .loop_mode  (~ctrl_q[`P2_LOOP_BIT]),
      .live_q     (p2_live),
      .stopped_q  (p2_stop),
      .done       (p2_done)
   );

   sample_counter #(.W(CW)) rec_counter (
      .clock      (clock),
      .rst        (rst),
      .reload     (rec_enable & ~rec_en_q),
      .load_value (rec_cnt_q),
      .tick       (rec_accept),
      .loop_mode  (~ctrl_q[`REC_LOOP_BIT]),
      .live_q     (rec_live),
      .stopped_q  (rec_stop),
      .done       (rec_done)
   );

   // Pending interrupts: a zero enable clears, so software must rewrite one
   always @(posedge clock)
   begin
      if (rst)
      begin
         p1_irq_q  <= 1'b0;
         p2_irq_q  <= 1'b0;
         rec_irq_q <= 1'b0;
      end
      else
      begin
         p1_irq_q  <= ctrl_q[`P1_IRQ_BIT] & (p1_irq_q | p1_done);
         p2_irq_q  <= ctrl_q[`P2_IRQ_BIT] & (p2_irq_q | p2_done);
         rec_irq_q <= ctrl_q[`REC_IRQ_BIT] & (rec_irq_q | rec_done);
      end
   end

endmodule

`default_nettype wire

// ==== bench/audio_channel_serial_control_properties.sv ====
// Concurrent checks on the ports of the serial channel control block.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "audio_serial_map.vh"

module audio_channel_serial_control_properties #(
   parameter CW = 16
) (
   // Clock and reset
   input wire logic        clock,
   input wire logic        rst,
   // Register port
   input wire logic [5:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [3:0]  reg_be,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata_q,
   // Playback one
   input wire logic        p1_enable,
   input wire logic        p1_fetch_valid,
   input wire logic        p1_fetch_ready,
   input wire logic [15:0] p1_left_q,
   // Record store and interrupt levels
   input wire logic [31:0] rec_store_data,
   input wire logic        rec_store_valid,
   input wire logic        rec_store_ready,
   input wire logic        p1_irq_q,
   input wire logic        p2_irq_q,
   input wire logic        rec_irq_q
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   // Control write with one interrupt enable low
   sequence enable_off_write(b);
      reg_wr && reg_addr == `CTRL_OFS && reg_be[1] && !reg_wdata[b];
   endsequence
   // Low control byte written, then read back two cycles later
   sequence ctrl_write_then_read;
      (reg_wr && reg_addr == `CTRL_OFS && reg_be[0]) ##2 (reg_rd && reg_addr == `CTRL_OFS);
   endsequence

   a_format_bits_kept: assert property (ctrl_write_then_read |=>
      reg_rdata_q[6:0] == $past(reg_wdata[6:0], 3)) else $error("format bits not kept");
   a_p1_irq_cleared: assert property (enable_off_write(8) |-> ##2 !p1_irq_q)
      else $error("playback one interrupt not cleared");
   a_p2_irq_cleared: assert property (enable_off_write(9) |-> ##2 !p2_irq_q)
      else $error("playback two interrupt not cleared");
   a_rec_irq_cleared: assert property (enable_off_write(10) |-> ##2 !rec_irq_q)
      else $error("record interrupt not cleared");
   a_fetch_once_frame: assert property (p1_fetch_ready |=> !p1_fetch_ready [*4])
      else $error("fetch pulses too close");
   a_idle_no_fetch: assert property (!p1_enable && $past(!p1_enable) |-> !p1_fetch_ready)
      else $error("fetch while disabled");
   a_p1_holds_between: assert property (!$past(p1_fetch_ready && p1_fetch_valid)
      |-> $stable(p1_left_q)) else $error("playback one changed without a take");
   a_store_word_waits: assert property (rec_store_valid && !rec_store_ready
      |=> rec_store_valid && $stable(rec_store_data)) else $error("record word lost");
   a_irq_after_frame: assert property ($rose(p1_irq_q)
      |-> $past(p1_fetch_ready) || $past(p1_fetch_ready, 2)) else $error("interrupt off frame");
endmodule

bind audio_channel_serial_control audio_channel_serial_control_properties #(.CW(CW)) props_u (
   .clock, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_be, .reg_wdata, .reg_rdata_q,
   .p1_enable, .p1_fetch_valid, .p1_fetch_ready, .p1_left_q, .rec_store_data,
   .rec_store_valid, .rec_store_ready, .p1_irq_q, .p2_irq_q, .rec_irq_q);
`default_nettype wire

// ==== bench/codec_link_model.sv ====
// Behavioural codec on the serial sample link: frame clock and record samples.
// Assumes the bench sets the next record pair; the frame clock runs free.
`timescale 1ns/1ps
`default_nettype none

module codec_link_model #(
   parameter real HALF_NS  = 400.0,
   parameter real PHASE_NS = 137.0
) (
   // Record pair to send next
   input  wire logic [15:0] next_left,
   input  wire logic [15:0] next_right,
   // Link toward the controller
   output var  logic        lrclk,
   output var  logic [15:0] rec_left_in,
   output var  logic [15:0] rec_right_in
);
   // Free-running frame clock, offset by PHASE_NS so its edges keep one fixed phase against the system clock
   initial
   begin
      lrclk = 1'b0;
      rec_left_in = 16'h0000;
      rec_right_in = 16'h0000;
      #(PHASE_NS);
      forever
      begin
         #(HALF_NS) lrclk = ~lrclk;
      end
   end
   // New pair on the fall so it is settled well before the sampling rise
   always @(negedge lrclk)
   begin
      rec_left_in  <= next_left;
      rec_right_in <= next_right;
   end
endmodule
`default_nettype wire

// ==== bench/audio_channel_serial_control_tb.sv ====
// Self-checking bench for the serial channel control block.
// Assumes the codec model makes the frame clock and record samples; every other input is driven here.
`timescale 1ns/1ps
`default_nettype none
`include "audio_serial_map.vh"

module audio_channel_serial_control_tb;
   // Bench-driven inputs
   logic        clock, rst, reg_wr, reg_rd, p1_enable, p2_enable, rec_enable;
   logic [5:0]  reg_addr;
   logic [3:0]  reg_be;
   logic [31:0] reg_wdata, p1_fetch_data, p2_fetch_data;
   logic        p1_fetch_valid, p2_fetch_valid, rec_store_ready;
   logic [15:0] next_left, next_right;
   // Design and model outputs
   logic [31:0] reg_rdata_q, rec_store_data;
   logic        lrclk, p1_fetch_ready, p2_fetch_ready, rec_store_valid;
   logic [15:0] rec_left_in, rec_right_in, p1_left_q, p1_right_q, p2_left_q, p2_right_q;
   logic        p1_irq_q, p2_irq_q, rec_irq_q;
   logic [1:0]  fm;
   int          bad_count, comparisons;

   audio_channel_serial_control #(.CW(16)) dut_u (.clock, .rst, .reg_addr, .reg_wr, .reg_rd,
      .reg_be, .reg_wdata, .reg_rdata_q, .lrclk, .rec_left_in, .rec_right_in, .p1_left_q,
      .p1_right_q, .p2_left_q, .p2_right_q, .p1_enable, .p2_enable, .rec_enable,
      .p1_fetch_data, .p1_fetch_valid, .p1_fetch_ready, .p2_fetch_data, .p2_fetch_valid,
      .p2_fetch_ready, .rec_store_data, .rec_store_valid, .rec_store_ready, .p1_irq_q,
      .p2_irq_q, .rec_irq_q);
   codec_link_model codec_u (.next_left, .next_right, .lrclk, .rec_left_in, .rec_right_in);

   // Expected codec slot: eight-bit samples move from the low byte to the high byte, msb turned round
   function automatic logic [15:0] pb_slot(input logic [15:0] h, input logic wide);
      pb_slot = wide ? h : {~h[7], h[6:0], 8'h00};
   endfunction
   // Expected {right, left} pair; mono copies the left slot
   function automatic logic [31:0] pb_pair(input logic [31:0] w, input logic [1:0] f);
      pb_pair = {f[0] ? pb_slot(w[31:16], f[1]) : pb_slot(w[15:0], f[1]), pb_slot(w[15:0], f[1])};
   endfunction
   // Expected stored record word; mono leaves the right half empty
   function automatic logic [31:0] rec_word(input logic [15:0] l, r, input logic [1:0] f);
      logic [15:0] a, b;
      a = f[1] ? l : {8'h00, ~l[15], l[14:8]};
      b = f[1] ? r : {8'h00, ~r[15], r[14:8]};
      rec_word = {f[0] ? b : 16'h0000, a};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      comparisons = comparisons + 1;
      if (seen !== want)
      begin
         bad_count = bad_count + 1;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask
   // One write strobe, held for exactly one sampling edge
   task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge clock);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      reg_be    <= be;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   // Read strobe, then the registered answer one edge later
   task automatic rd(input logic [5:0] a, input logic [31:0] want);
      @(posedge clock);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(posedge clock);
      check(reg_rdata_q, want);
   endtask
   // Frames land three clocks after a rise; five leaves the outputs settled
   task automatic frame(input int n);
      repeat (n)
      begin
         @(posedge lrclk);
         repeat (5) @(posedge clock);
      end
   endtask
   // Take one buffered record word after checking it
   task automatic pop(input logic [31:0] want);
      check(32'(rec_store_valid), 32'h1);
      check(rec_store_data, want);
      rec_store_ready <= 1'b1;
      @(posedge clock);
      rec_store_ready <= 1'b0;
      @(posedge clock);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // 10 MHz system clock
   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   // Watchdog well beyond the 34 frames the run needs
   initial
   begin
      #2000000;
      bad_count = bad_count + 1;
      tally_and_finish();
   end

   initial
   begin
      {rst, reg_wr, reg_rd, p1_enable, p2_enable, rec_enable} = 6'h20;
      {reg_addr, reg_be, reg_wdata} = 42'h0;
      {p1_fetch_valid, p2_fetch_valid, rec_store_ready} = 3'h7;
      {next_left, next_right} = 32'hC3A55A3C;
      p1_fetch_data = 32'h9A3C5B71;
      p2_fetch_data = 32'h6D2E81F4;
      bad_count = 0;
      comparisons = 0;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      // Reset values, read-only counter half, byte lane, unmapped hole
      rd(`CTRL_OFS, `CTRL_RESET);
      wr(`P1_COUNT_OFS, 32'hFFFF0005, 4'hF);
      rd(`P1_COUNT_OFS, 32'h00000005);
      wr(`CTRL_OFS, 32'hFFFFFF33, 4'h1);
      rd(`CTRL_OFS, 32'hFF800033);
      rd(6'h04, 32'h0);
      // Every format code on all three channels, with the record side stalled
      {p1_enable, p2_enable, rec_enable} <= 3'h7;
      for (int f = 0; f < 4; f++)
      begin
         fm = f[1:0];
         rec_store_ready <= 1'b1;
         wr(`CTRL_OFS, {26'h0, fm, fm, fm}, 4'hF);
         frame(1);
         rec_store_ready <= 1'b0;
         frame(3);
         check({p1_right_q, p1_left_q}, pb_pair(p1_fetch_data, fm));
         check({p2_right_q, p2_left_q}, pb_pair(p2_fetch_data, fm));
         check(32'({rec_irq_q, p2_irq_q, p1_irq_q}), 32'h0);
         pop(rec_word(next_left, next_right, fm));
         pop(rec_word(next_left, next_right, fm));
         check(32'(rec_store_valid), 32'h0);
      end
      // Hold repeats the old sample; clearing it takes the new one
      wr(`CTRL_OFS, 32'h00000803, 4'hF);
      p1_fetch_data <= 32'h1234ABCD;
      frame(2);
      check({p1_right_q, p1_left_q}, 32'h9A3C5B71);
      wr(`CTRL_OFS, 32'h00000003, 4'hF);
      frame(1);
      check({p1_right_q, p1_left_q}, 32'h1234ABCD);
      // Loop-mode interrupts raised, cleared by a zero write, then rearmed
      rec_store_ready <= 1'b1;
      wr(`CTRL_OFS, 32'h00000603, 4'hF);
      frame(2);
      check(32'({rec_irq_q, p2_irq_q, p1_irq_q}), 32'h6);
      wr(`CTRL_OFS, 32'h00000003, 4'hF);
      repeat (2) @(posedge clock);
      check(32'({rec_irq_q, p2_irq_q, p1_irq_q}), 32'h0);
      wr(`CTRL_OFS, 32'h00000603, 4'hF);
      frame(1);
      check(32'({rec_irq_q, p2_irq_q, p1_irq_q}), 32'h6);
      // Stop mode: count of three means four frames, then hold the last sample
      p1_enable <= 1'b0;
      wr(`P1_COUNT_OFS, 32'h00000003, 4'h3);
      wr(`CTRL_OFS, 32'h00002103, 4'hF);
      frame(1);
      p1_enable <= 1'b1;
      frame(2);
      rd(`P1_COUNT_OFS, 32'h00010003);
      frame(1);
      check(32'(p1_irq_q), 32'h0);
      frame(1);
      check(32'(p1_irq_q), 32'h1);
      p1_fetch_data <= 32'h0F0F0F0F;
      frame(1);
      check({p1_right_q, p1_left_q}, 32'h1234ABCD);
      wr(`CTRL_OFS, 32'h00002003, 4'hF);
      repeat (2) @(posedge clock);
      check(32'(p1_irq_q), 32'h0);
      // Reload edge loads the count only at the following frame
      wr(`P1_COUNT_OFS, 32'h00000002, 4'h3);
      frame(1);
      wr(`CTRL_OFS, 32'h00002083, 4'hF);
      rd(`P1_COUNT_OFS, 32'h00000002);
      frame(1);
      rd(`P1_COUNT_OFS, 32'h00010002);
      // Disabled playback two: last sample in stop mode with keep set, else zeros
      wr(`CTRL_OFS, 32'h0000404F, 4'hF);
      frame(1);
      p2_enable <= 1'b0;
      frame(2);
      check({p2_right_q, p2_left_q}, 32'h6D2E81F4);
      wr(`CTRL_OFS, 32'h0000400F, 4'hF);
      frame(1);
      check({p2_right_q, p2_left_q}, 32'h00000000);
      tally_and_finish();
   end
endmodule
`default_nettype wire
